// ===== plt_chk.sv
`timescale 1ns/1ns
module plt_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmh_wr_en,
  input wire logic [10:0] cmh_addr,
  input wire logic [15:0] cmh_wdata,
  input wire logic [15:0] cmh_rdata,
  input wire logic qfr_wr_en,
  input wire logic [4:0] qfr_addr,
  input wire logic [15:0] qfr_wdata,
  input wire logic [15:0] qfr_rdata,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [10:0] out_channel,
  input wire logic [7:0] out_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rst_vals_a: assert property (
    $rose(rst_n) |-> !out_valid && in_ready && cmh_rdata == 16'h0000 && qfr_rdata == 16'h0000)
    else $error("outputs not cleared by reset");
  pad_zero_a: assert property (
    cmh_rdata[15:5] == 11'h000 && qfr_rdata[15:12] == 4'h0)
    else $error("unused read bits not zero");
  cmh_back_a: assert property (
    cmh_wr_en ##1 (!cmh_wr_en && cmh_addr == $past(cmh_addr))
    |=> cmh_rdata[4:0] == $past(cmh_wdata[4:0], 2))
    else $error("entry readback differs");
  qfr_back_a: assert property (
    qfr_wr_en ##1 (!qfr_wr_en && qfr_addr == $past(qfr_addr))
    |=> qfr_rdata[11:0] == $past(qfr_wdata[11:0], 2))
    else $error("quadrant readback differs");
  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_channel))
    else $error("output word not held");
  drop_ready_a: assert property (
    $fell(out_valid) |-> $past(out_ready))
    else $error("output word dropped");
  full_valid_a: assert property (
    !in_ready |-> out_valid)
    else $error("buffer full without output");
  free_slot_a: assert property (
    !in_ready && out_ready |=> in_ready)
    else $error("slot not freed");
endmodule : plt_chk
bind plt_codec plt_chk chk_u (.sys_clk, .rst_n, .cmh_wr_en, .cmh_addr, .cmh_wdata,
  .cmh_rdata, .qfr_wr_en, .qfr_addr, .qfr_wdata, .qfr_rdata, .in_ready, .out_valid,
  .out_ready, .out_channel, .out_data);

// ===== plt_codec.sv
// Contract
// - Translate per output channel, every switching mode
// - Entry bit 4: zero voice, one data
// - Input law bits 3-2, output 1-0
// - Voice 00 A-law, 01 mu-law
// - Voice 10 A-law without even inversion
// - Voice 11 mu-law without magnitude inversion
// - Data 00 leaves octet untouched
// - Data 01 inverts even bits
// - Data 10 inverts odd bits
// - Data 11 inverts all bits
// - Convert differing laws, pass equal ones
// - Never mix voice law with data scheme
// - Four equal channel quadrants per rate
// - Quadrant fields at 11-9, 8-6, 5-3, 2-0
// - 0xx none, 10x LSB, 11x MSB forced
`timescale 1ns/1ns
module plt_codec
  import plt_pkg::*;
#(
  parameter int OUT_CHANNELS = plt_pkg::NUM_OUT_CH,
  parameter int STREAMS = plt_pkg::NUM_STREAMS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmh_wr_en,
  input wire logic [plt_pkg::OUT_CH_AW-1:0] cmh_addr,
  input wire logic [plt_pkg::CMH_BUS_W-1:0] cmh_wdata,
  output logic [plt_pkg::CMH_BUS_W-1:0] cmh_rdata,
  input wire logic qfr_wr_en,
  input wire logic [plt_pkg::STREAM_AW-1:0] qfr_addr,
  input wire logic [plt_pkg::QFR_BUS_W-1:0] qfr_wdata,
  output logic [plt_pkg::QFR_BUS_W-1:0] qfr_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [plt_pkg::STREAM_AW-1:0] in_stream,
  input wire logic [plt_pkg::RATE_W-1:0] in_rate,
  input wire logic [plt_pkg::IN_CH_W-1:0] in_channel,
  input wire logic [plt_pkg::OUT_CH_AW-1:0] in_out_channel,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [plt_pkg::OUT_CH_AW-1:0] out_channel,
  output logic [7:0] out_data
);
  import plt_pkg::*;

  // Connection memory high entries and quadrant force registers
  logic [CMH_W-1:0] cmh_mem [OUT_CHANNELS];
  logic [CMH_W-1:0] next_cmh_mem [OUT_CHANNELS];
  logic [QFR_USED_W-1:0] qfr_mem [STREAMS];
  logic [QFR_USED_W-1:0] next_qfr_mem [STREAMS];
  logic [CMH_BUS_W-1:0] next_cmh_rdata;
  logic [QFR_BUS_W-1:0] next_qfr_rdata;

  always_comb begin
    next_cmh_mem = cmh_mem;
    next_qfr_mem = qfr_mem;
    if (cmh_wr_en) begin
      next_cmh_mem[cmh_addr] = cmh_wdata[CMH_W-1:0];
    end
    if (qfr_wr_en) begin
      next_qfr_mem[qfr_addr] = qfr_wdata[QFR_USED_W-1:0];
    end
    next_cmh_rdata = {{(CMH_BUS_W-CMH_W){1'b0}}, cmh_mem[cmh_addr]};
    next_qfr_rdata = {{(QFR_BUS_W-QFR_USED_W){1'b0}}, qfr_mem[qfr_addr]};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < OUT_CHANNELS; i++) begin
        cmh_mem[i] <= CMH_RESET;
      end
      for (int i = 0; i < STREAMS; i++) begin
        qfr_mem[i] <= QFR_RESET;
      end
      cmh_rdata <= '0;
      qfr_rdata <= '0;
    end else begin
      cmh_mem <= next_cmh_mem;
      qfr_mem <= next_qfr_mem;
      cmh_rdata <= next_cmh_rdata;
      qfr_rdata <= next_qfr_rdata;
    end
  end

  // Input side: quadrant bit forcing before switching
  logic [7:0] forced_data;

  plt_quad_force u_force (
    .rate(in_rate),
    .channel(in_channel),
    .quad_force_register(qfr_mem[in_stream]),
    .data_in(in_data),
    .data_out(forced_data)
  );

  // Two-entry buffer between input and output stage
  logic [7:0] buf_data [2];
  logic [OUT_CH_AW-1:0] buf_ch [2];
  logic buf_wr_ptr;
  logic buf_rd_ptr;
  logic [1:0] buf_count;
  logic [7:0] next_buf_data [2];
  logic [OUT_CH_AW-1:0] next_buf_ch [2];
  logic next_buf_wr_ptr;
  logic next_buf_rd_ptr;
  logic [1:0] next_buf_count;
  logic push;
  logic pop;
  logic stage_ready;
  logic head_valid;

  assign in_ready = (buf_count != 2'h2);
  assign head_valid = (buf_count != 2'h0);
  assign stage_ready = !out_valid || out_ready;
  assign push = in_valid && in_ready;
  assign pop = head_valid && stage_ready;

  always_comb begin
    next_buf_data = buf_data;
    next_buf_ch = buf_ch;
    next_buf_wr_ptr = buf_wr_ptr;
    next_buf_rd_ptr = buf_rd_ptr;
    next_buf_count = buf_count;
    if (push) begin
      next_buf_data[buf_wr_ptr] = forced_data;
      next_buf_ch[buf_wr_ptr] = in_out_channel;
      next_buf_wr_ptr = ~buf_wr_ptr;
    end
    if (pop) begin
      next_buf_rd_ptr = ~buf_rd_ptr;
    end
    if (push && !pop) next_buf_count = buf_count + 2'h1;
    if (pop && !push) next_buf_count = buf_count - 2'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
      buf_ch[0] <= '0;
      buf_ch[1] <= '0;
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
      buf_count <= 2'h0;
    end else begin
      buf_data <= next_buf_data;
      buf_ch <= next_buf_ch;
      buf_wr_ptr <= next_buf_wr_ptr;
      buf_rd_ptr <= next_buf_rd_ptr;
      buf_count <= next_buf_count;
    end
  end

  // Output side: translation with the output channel's entry
  logic [7:0] translated;
  logic next_out_valid;
  logic [OUT_CH_AW-1:0] next_out_channel;
  logic [7:0] next_out_data;

  plt_law_translate u_translate (
    .connection_memory_high_entry(cmh_mem[buf_ch[buf_rd_ptr]]),
    .data_in(buf_data[buf_rd_ptr]),
    .data_out(translated)
  );

  always_comb begin
    next_out_valid = out_valid;
    next_out_channel = out_channel;
    next_out_data = out_data;
    if (stage_ready) begin
      next_out_valid = head_valid;
      if (head_valid) begin
        next_out_channel = buf_ch[buf_rd_ptr];
        next_out_data = translated;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_channel <= '0;
      out_data <= 8'h00;
    end else begin
      out_valid <= next_out_valid;
      out_channel <= next_out_channel;
      out_data <= next_out_data;
    end
  end

endmodule : plt_codec

// ===== plt_law_translate.sv
`timescale 1ns/1ns
module plt_law_translate
  import plt_pkg::*;
(
  input wire logic [plt_pkg::CMH_W-1:0] connection_memory_high_entry,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  import plt_pkg::*;

  function automatic logic [7:0] voice_mask(input logic [LAW_W-1:0] law);
    logic [7:0] m;
    m = MASK_NONE;
    if (law == LAW_A_PLAIN) m = MASK_EVEN;
    if (law == LAW_MU_PLAIN) m = MASK_MAG;
    return m;
  endfunction : voice_mask

  function automatic logic [7:0] data_mask(input logic [LAW_W-1:0] law);
    logic [7:0] m;
    case (law)
      DATA_NONE: m = MASK_NONE;
      DATA_EVEN: m = MASK_EVEN;
      DATA_ODD: m = MASK_ODD;
      default: m = MASK_ALL;
    endcase
    return m;
  endfunction : data_mask

  function automatic logic [15:0] a_mag(input logic [7:0] a);
    logic [7:0] x;
    logic [15:0] t;
    x = a ^ MASK_EVEN;
    t = {8'h00, x[3:0], 4'h0};
    if (x[6:4] == 3'h0) t = t + 16'h0008;
    else t = (t + 16'h0108) << (x[6:4] - 3'h1);
    return t;
  endfunction : a_mag

  function automatic logic [15:0] u_mag(input logic [7:0] u);
    logic [7:0] x;
    logic [15:0] t;
    x = ~u;
    t = ({9'h000, x[3:0], 3'h0} + 16'h0084) << x[6:4];
    return t - 16'h0084;
  endfunction : u_mag

  function automatic logic [7:0] to_a(input logic pos, input logic [15:0] mag);
    logic [15:0] p;
    logic [3:0] seg;
    logic [7:0] v;
    p = pos ? (mag >> 3) : (((mag + 16'h0007) >> 3) - 16'h0001);
    // Negative zero would wrap to the largest step
    if (!pos && mag == 16'h0000) p = 16'h0000;
    seg = 4'h8;
    for (int s = 7; s >= 0; s--) begin
      if (p < (16'h0020 << s)) seg = 4'(s);
    end
    if (seg == 4'h8) v = MASK_MAG;
    else if (seg < 4'h2) v = {seg[2:0], p[4:1]};
    else v = {seg[2:0], 4'(p >> seg)};
    return v ^ (pos ? MASK_A_POS : MASK_EVEN);
  endfunction : to_a

  function automatic logic [7:0] to_u(input logic pos, input logic [15:0] mag);
    logic [15:0] p;
    logic [3:0] seg;
    logic [7:0] v;
    p = pos ? (mag >> 2) : ((mag + 16'h0003) >> 2);
    if (p > 16'h1FFF) p = 16'h1FFF;
    p = p + 16'h0021;
    seg = 4'h8;
    for (int s = 7; s >= 0; s--) begin
      if (p < (16'h0040 << s)) seg = 4'(s);
    end
    if (seg == 4'h8) v = MASK_MAG;
    else v = {seg[2:0], 4'(p >> (seg + 4'h1))};
    return v ^ (pos ? MASK_ALL : MASK_MAG);
  endfunction : to_u

  logic voice;
  logic [LAW_W-1:0] in_law;
  logic [LAW_W-1:0] out_law;
  logic [7:0] std_code;
  logic [7:0] mid_code;

  always_comb begin
    voice = ~connection_memory_high_entry[CMH_VOICE_DATA_BIT];
    in_law = connection_memory_high_entry[CMH_IN_LAW_LO +: LAW_W];
    out_law = connection_memory_high_entry[CMH_OUT_LAW_LO +: LAW_W];
    std_code = data_in ^ voice_mask(in_law);
    mid_code = std_code;
    if (in_law == out_law) begin
      data_out = data_in;
    end else if (!voice) begin
      data_out = data_in ^ data_mask(in_law) ^ data_mask(out_law);
    end else begin
      // Bit 0 of the law code picks the A or mu family
      if (!in_law[0] && out_law[0]) mid_code = to_u(std_code[7], a_mag(std_code));
      if (in_law[0] && !out_law[0]) mid_code = to_a(std_code[7], u_mag(std_code));
      data_out = mid_code ^ voice_mask(out_law);
    end
  end

endmodule : plt_law_translate

// ===== plt_pkg.sv
package plt_pkg;

  // Connection memory high entry layout
  localparam int CMH_W = 5;
  localparam int CMH_VOICE_DATA_BIT = 4;
  localparam int CMH_IN_LAW_LO = 2;
  localparam int CMH_OUT_LAW_LO = 0;
  localparam int LAW_W = 2;
  localparam logic [CMH_W-1:0] CMH_RESET = 5'h00;

  // Coding field values (voice and data share the codes)
  localparam logic [LAW_W-1:0] LAW_A = 2'h0;
  localparam logic [LAW_W-1:0] LAW_MU = 2'h1;
  localparam logic [LAW_W-1:0] LAW_A_PLAIN = 2'h2;
  localparam logic [LAW_W-1:0] LAW_MU_PLAIN = 2'h3;
  localparam logic [LAW_W-1:0] DATA_NONE = 2'h0;
  localparam logic [LAW_W-1:0] DATA_EVEN = 2'h1;
  localparam logic [LAW_W-1:0] DATA_ODD = 2'h2;
  localparam logic [LAW_W-1:0] DATA_ALL = 2'h3;

  // Inversion masks
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_EVEN = 8'h55;
  localparam logic [7:0] MASK_ODD = 8'hAA;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_MAG = 8'h7F;
  localparam logic [7:0] MASK_A_POS = 8'hD5;

  // Quadrant force register layout
  localparam int QF_FIELD_W = 3;
  localparam int QF_FIELDS = 4;
  localparam int QFR_USED_W = QF_FIELD_W * QF_FIELDS;
  localparam int QFR_BUS_W = 16;
  localparam logic [QFR_USED_W-1:0] QFR_RESET = 12'h000;
  localparam int QF_ENABLE_BIT = 2;
  localparam int QF_MSB_SEL_BIT = 1;
  localparam int QF_VALUE_BIT = 0;
  localparam logic [2:0] QUAD_BASE_SHIFT = 3'h3;

  // Geometry
  localparam int NUM_STREAMS = 32;
  localparam int STREAM_AW = 5;
  localparam int IN_CH_W = 8;
  localparam int RATE_W = 2;
  localparam int NUM_OUT_CH = 2048;
  localparam int OUT_CH_AW = 11;
  localparam int CMH_BUS_W = 16;

endpackage : plt_pkg

// ===== plt_quad_force.sv
`timescale 1ns/1ns
module plt_quad_force
  import plt_pkg::*;
(
  input wire logic [plt_pkg::RATE_W-1:0] rate,
  input wire logic [plt_pkg::IN_CH_W-1:0] channel,
  input wire logic [plt_pkg::QFR_USED_W-1:0] quad_force_register,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  import plt_pkg::*;

  logic [IN_CH_W-1:0] shifted;
  logic [1:0] quadrant;
  logic [QF_FIELD_W-1:0] quadrant_force_field;

  always_comb begin
    // Quadrant is the top two bits of the channel count per rate
    shifted = channel >> (QUAD_BASE_SHIFT + {1'b0, rate});
    quadrant = shifted[1:0];
    quadrant_force_field = quad_force_register[quadrant*QF_FIELD_W +: QF_FIELD_W];
    data_out = data_in;
    if (quadrant_force_field[QF_ENABLE_BIT]) begin
      if (quadrant_force_field[QF_MSB_SEL_BIT]) begin
        data_out[7] = quadrant_force_field[QF_VALUE_BIT];
      end else begin
        data_out[0] = quadrant_force_field[QF_VALUE_BIT];
      end
    end
  end

endmodule : plt_quad_force

// ===== plt_sink.sv
`timescale 1ns/1ns
module plt_sink (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  output logic out_ready
);
  initial out_ready = 1'b0;
  // Random back-pressure when stalling
  always @(posedge sys_clk) begin
    out_ready <= #1 rst_n && (!stall || 1'($urandom));
  end
endmodule : plt_sink

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import plt_pkg::*;
  logic sys_clk, rst_n, cmh_wr_en, qfr_wr_en, in_valid, in_ready, out_valid, out_ready, stall;
  logic [10:0] cmh_addr, in_out_channel, out_channel;
  logic [15:0] cmh_wdata, cmh_rdata, qfr_wdata, qfr_rdata, qv;
  logic [4:0] qfr_addr, in_stream, cm;
  logic [1:0] in_rate;
  logic [7:0] in_channel, in_data, out_data;
  logic [18:0] exq[$];
  logic [11:0] qm[32] = '{default: 12'h000};
  int miscompares = 0;
  int tests_run = 0;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  plt_codec dut_u (.sys_clk, .rst_n, .cmh_wr_en, .cmh_addr, .cmh_wdata, .cmh_rdata,
    .qfr_wr_en, .qfr_addr, .qfr_wdata, .qfr_rdata, .in_valid, .in_ready, .in_stream,
    .in_rate, .in_channel, .in_out_channel, .in_data, .out_valid, .out_ready,
    .out_channel, .out_data);
  plt_sink snk_u (.sys_clk, .rst_n, .stall, .out_ready);
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] xl(input logic [4:0] c, input logic [7:0] d);
    logic [3:0][7:0] m;
    m = c[4] ? 32'hFFAA5500 : 32'h00007F55;
    if (c[3:2] == c[1:0]) return d;
    return d ^ m[c[3:2]] ^ m[c[1:0]];
  endfunction : xl
  function automatic logic [7:0] fq(input logic [11:0] r, input logic [1:0] rt,
      input logic [7:0] ch, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] f;
    q = ch >> (3 + rt);
    f = r[q[1:0]*3 +: 3];
    if (f[2] && f[1]) d[7] = f[0];
    if (f[2] && !f[1]) d[0] = f[0];
    return d;
  endfunction : fq
  task automatic wr(input logic c, input logic [10:0] a, input logic [15:0] d);
    cmh_wr_en = c;
    qfr_wr_en = !c;
    cmh_addr = a;
    qfr_addr = a[4:0];
    cmh_wdata = d;
    qfr_wdata = d;
    @(posedge sys_clk) #1;
    cmh_wr_en = 1'b0;
    qfr_wr_en = 1'b0;
    repeat (2) @(posedge sys_clk) #1;
    if (c) chk({3'h0, cmh_rdata}, {14'h0, d[4:0]});
    else chk({3'h0, qfr_rdata}, {7'h0, d[11:0]});
  endtask : wr
  task automatic send(input logic [4:0] s, input logic [10:0] oc, input logic [4:0] c,
      input logic fix = 1'b0, input logic [7:0] fd = 8'h00, input logic [7:0] fe = 8'h00);
    logic r;
    logic [1:0] rt;
    logic [7:0] ch, d;
    rt = 2'($urandom);
    ch = 8'($urandom % (32 << rt));
    d = 8'($urandom);
    if (fix) d = fd;
    in_valid = 1'b1;
    in_stream = s;
    in_rate = rt;
    in_channel = ch;
    in_out_channel = oc;
    in_data = d;
    do begin
      r = in_ready;
      @(posedge sys_clk) #1;
    end while (r !== 1'b1);
    exq.push_back({oc, fix ? fe : xl(c, fq(qm[s], rt, ch, d))});
  endtask : send
  always @(posedge sys_clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exq.size() == 0) chk({out_channel, out_data}, 19'hX);
      else chk({out_channel, out_data}, exq.pop_front());
    end
  end
  initial begin
    {rst_n, cmh_wr_en, qfr_wr_en, in_valid, stall} = '0;
    {cmh_addr, cmh_wdata, qfr_addr, qfr_wdata} = '0;
    {in_stream, in_rate, in_channel, in_out_channel, in_data} = '0;
    void'($urandom(66717));
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk) #1;
    chk({3'h0, cmh_rdata}, 19'h0);
    chk({3'h0, qfr_rdata}, 19'h0);
    chk({17'h0, out_valid, in_ready}, 19'h1);
    for (int k = 0; k < 32; k++) begin
      cm = 5'(k);
      if (!cm[4] && cm[2] != cm[0]) continue;
      qv = 16'($urandom);
      wr(1'b1, 11'(k * 37), {11'($urandom), cm});
      // Forcing only, random fields for stream k
      wr(1'b0, 11'(k), qv);
      qm[k] = qv[11:0];
      stall = k[0];
      repeat (6) send(5'($urandom), 11'(k * 37), cm);
      in_valid = 1'b0;
      repeat (40) @(posedge sys_clk) #1;
      $display("test %0d done", k);
    end
    // Cross-family voice vectors, stream 0 unforced
    stall = 1'b0;
    wr(1'b0, 11'h000, 16'h0000);
    qm[0] = 12'h000;
    wr(1'b1, 11'h7FF, 16'h0001);
    send(5'h00, 11'h7FF, 5'h01, 1'b1, 8'hD5, 8'hFE);
    send(5'h00, 11'h7FF, 5'h01, 1'b1, 8'h55, 8'h7E);
    in_valid = 1'b0;
    repeat (10) @(posedge sys_clk) #1;
    wr(1'b1, 11'h7FF, 16'h0004);
    send(5'h00, 11'h7FF, 5'h04, 1'b1, 8'hFF, 8'hD5);
    send(5'h00, 11'h7FF, 5'h04, 1'b1, 8'h7F, 8'h55);
    send(5'h00, 11'h7FF, 5'h04, 1'b1, 8'h80, 8'hAA);
    in_valid = 1'b0;
    repeat (10) @(posedge sys_clk) #1;
    $display("test cross-family done");
    chk(19'(exq.size()), 19'h0);
    give_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
